// File: logic/cevs_regs.svh
// Register offsets, field positions, reset values and vector offsets of the
// exception selection block. Assumes inclusion by bare name.
`ifndef CEVS_REGS_SVH
`define CEVS_REGS_SVH
`define CEVS_ADDR_BKPT 4'h0
`define CEVS_ADDR_CTRL 4'h1
`define CEVS_ADDR_STAT 4'h2
`define CEVS_ADDR_VEC 4'h3
`define CEVS_ADDR_ALN 4'h4
`define CEVS_BKPT_RESET 32'h00000000
`define CEVS_BKPT_EN_BIT 1
`define CEVS_CTRL_RESET 32'h00000000
`define CEVS_CTRL_EXT_EN_BIT 0
`define CEVS_CTRL_LITTLE_BIT 1
`define CEVS_CTRL_IP_BIT 2
`define CEVS_PREFIX_HI 32'hfff00000
`define CEVS_PREFIX_LO 32'h00000000
`define CEVS_VEC_NONE 20'h00000
`define CEVS_VEC_FP_ASSIST 20'h00e00
`define CEVS_VEC_ITMISS 20'h01000
`define CEVS_VEC_DLMISS 20'h01100
`define CEVS_VEC_DSMISS 20'h01200
`define CEVS_VEC_BKPT 20'h01300
`define CEVS_VEC_MGMT 20'h01400
`endif

// File: logic/cevs_pkg.sv
// Types shared by the exception selection block.
// Assumes the register header is compiled alongside.
package cevs_pkg;
    typedef enum logic [2:0] {
        CEVS_C_NONE = 3'h0,
        CEVS_C_ITMISS = 3'h1,
        CEVS_C_DLMISS = 3'h3,
        CEVS_C_DSMISS = 3'h2,
        CEVS_C_BKPT = 3'h6,
        CEVS_C_MGMT = 3'h7
    } cevs_cause_t;
    typedef struct packed {
        logic fetch_valid;
        logic fetch_tb_miss;
        logic load_valid;
        logic store_valid;
        logic data_tb_miss;
        logic changed_bit_needed;
        logic complete_valid;
        logic [31:0] complete_addr;
    } cevs_core_evt_t;
    typedef struct packed {
        logic valid;
        logic fp_operand;
        logic multiple_or_reserved;
        logic ext_control;
        logic multiple_or_string;
    } cevs_align_t;
    typedef struct packed {
        logic take;
        logic [31:0] addr;
        logic [19:0] offset;
        cevs_cause_t cause;
    } cevs_exc_t;
endpackage

// File: logic/cevs_align_rank.sv
// Alignment cause ranking, combinational.
// Assumes cause flags are valid in the same cycle as the valid bit.
`timescale 1ns/100ps
module cevs_align_rank (
    input wire cevs_pkg::cevs_align_t i_align,
    input wire logic i_little_mode,
    output logic [2:0] o_rank
);
    import cevs_pkg::*;
    always_comb begin
        o_rank = 3'h0;
        if (i_align.valid) begin
            if (i_align.fp_operand) begin
                o_rank = 3'h1; // RULE10
            end else if (i_align.multiple_or_reserved) begin
                o_rank = 3'h2; // RULE10
            end else if (i_align.ext_control) begin
                o_rank = 3'h3; // RULE10
            end else if (i_align.multiple_or_string && i_little_mode) begin
                o_rank = 3'h4; // RULE10
            end
        end
    end
endmodule

// File: logic/cevs_sync2.sv
// Two-flop synchroniser for a pin level.
// Assumes the pin is asynchronous to i_ref_clk.
`timescale 1ns/100ps
module cevs_sync2 (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_pin,
    output logic o_level
);
    logic [1:0] stage;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            stage <= 2'h3;
        end else if (i_ce) begin
            stage <= {stage[0], i_pin};
        end
    end
    assign o_level = stage[1];
endmodule

// File: logic/cevs_top.sv
// Exception cause selection and entry address forming for the core.
// Assumes same-clock event inputs from fetch, load/store and completion;
// the management request pin is asynchronous and active low.
// Operation
// RULE1 - Floating-point assist vector is never selected.
// RULE2 - Fetch translation miss takes vector 01000.
// RULE3 - Load translation miss takes vector 01100.
// RULE4 - Store translation miss takes vector 01200.
// RULE5 - Store hit needing changed bit set also takes 01200.
// RULE6 - Breakpoint when bits 0-29 match next completing address.
// RULE7 - Breakpoint needs enable bit 30 set.
// RULE8 - Management interrupt when request asserted and external enable is 1.
// RULE9 - System logic drives the active-low request; honoured only when enabled.
// RULE10 - Alignment ranking: FP, multiple/reserved, external control, LE string.
// RULE11 - Entry address is prefix plus offset; reserved offsets never chosen.
`timescale 1ns/100ps
`include "cevs_regs.svh"
module cevs_top (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire cevs_pkg::cevs_core_evt_t i_evt,
    input wire cevs_pkg::cevs_align_t i_align,
    input wire logic i_mgmt_req_n,
    output cevs_pkg::cevs_exc_t o_exc,
    output logic [2:0] o_align_rank
);
    import cevs_pkg::*;

    typedef struct packed {
        logic [31:0] bkpt;
        logic [31:0] ctrl;
        logic [31:0] rdata;
        cevs_exc_t exc;
        logic [2:0] arank;
        logic [7:0] seen;
    } cevs_state_t;

    cevs_state_t st;
    cevs_state_t next_st;
    logic mgmt_n_sync;
    logic [2:0] rank_now;

    cevs_sync2 u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin(i_mgmt_req_n),
        .o_level(mgmt_n_sync)
    );

    cevs_align_rank u_rank (
        .i_align(i_align),
        .i_little_mode(st.ctrl[`CEVS_CTRL_LITTLE_BIT]),
        .o_rank(rank_now)
    );

    // Offset for a cause; floating-point assist has no cause code so it cannot appear
    function automatic logic [19:0] cevs_offset(input cevs_cause_t c);
        case (c)
            CEVS_C_ITMISS: cevs_offset = `CEVS_VEC_ITMISS; // RULE2
            CEVS_C_DLMISS: cevs_offset = `CEVS_VEC_DLMISS; // RULE3
            CEVS_C_DSMISS: cevs_offset = `CEVS_VEC_DSMISS; // RULE4
            CEVS_C_BKPT: cevs_offset = `CEVS_VEC_BKPT; // RULE6
            CEVS_C_MGMT: cevs_offset = `CEVS_VEC_MGMT; // RULE8
            default: cevs_offset = `CEVS_VEC_NONE; // RULE1
        endcase
    endfunction

    logic bkpt_hit;
    logic mgmt_hit;
    logic itm_hit;
    logic dlm_hit;
    logic dsm_hit;
    cevs_cause_t cause;

    always_comb begin
        // Bits 0-29 in big-endian numbering are [31:2] here
        bkpt_hit = i_evt.complete_valid && st.bkpt[`CEVS_BKPT_EN_BIT] &&
            (st.bkpt[31:2] == i_evt.complete_addr[31:2]); // RULE6 RULE7
        mgmt_hit = !mgmt_n_sync && st.ctrl[`CEVS_CTRL_EXT_EN_BIT]; // RULE8 RULE9
        itm_hit = i_evt.fetch_valid && i_evt.fetch_tb_miss; // RULE2
        dlm_hit = i_evt.load_valid && i_evt.data_tb_miss; // RULE3
        dsm_hit = i_evt.store_valid &&
            (i_evt.data_tb_miss || i_evt.changed_bit_needed); // RULE4 RULE5
        // Completion-side events outrank fetch-side ones
        if (bkpt_hit) begin
            cause = CEVS_C_BKPT;
        end else if (dlm_hit) begin
            cause = CEVS_C_DLMISS;
        end else if (dsm_hit) begin
            cause = CEVS_C_DSMISS;
        end else if (mgmt_hit) begin
            cause = CEVS_C_MGMT;
        end else if (itm_hit) begin
            cause = CEVS_C_ITMISS;
        end else begin
            cause = CEVS_C_NONE;
        end
    end

    always_comb begin
        next_st = st;
        next_st.exc.take = (cause != CEVS_C_NONE);
        next_st.exc.cause = cause;
        next_st.exc.offset = cevs_offset(cause);
        next_st.exc.addr = (st.ctrl[`CEVS_CTRL_IP_BIT] ? `CEVS_PREFIX_HI : `CEVS_PREFIX_LO)
            | {12'h000, cevs_offset(cause)}; // RULE11
        next_st.arank = rank_now;
        next_st.seen = st.seen;
        if (cause != CEVS_C_NONE) begin
            next_st.seen[cause] = 1'b1;
        end
        if (i_wr) begin
            case (i_addr)
                `CEVS_ADDR_BKPT: next_st.bkpt = {i_wdata[31:2], i_wdata[1], 1'b0};
                `CEVS_ADDR_CTRL: next_st.ctrl = {29'h0, i_wdata[2:0]};
                // Write-one-to-clear; a cause seen in the same cycle stays set
                `CEVS_ADDR_STAT: begin
                    next_st.seen = st.seen & ~i_wdata[7:0];
                    if (cause != CEVS_C_NONE) begin
                        next_st.seen[cause] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        next_st.rdata = 32'h0;
        if (i_rd) begin
            case (i_addr)
                `CEVS_ADDR_BKPT: next_st.rdata = st.bkpt;
                `CEVS_ADDR_CTRL: next_st.rdata = st.ctrl;
                `CEVS_ADDR_STAT: next_st.rdata = {23'h0, !mgmt_n_sync, st.seen};
                `CEVS_ADDR_VEC: next_st.rdata = st.exc.addr;
                `CEVS_ADDR_ALN: next_st.rdata = {29'h0, st.arank};
                default: next_st.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
            st.bkpt <= `CEVS_BKPT_RESET;
            st.ctrl <= `CEVS_CTRL_RESET;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_exc = st.exc;
    assign o_align_rank = st.arank;
endmodule

// File: testbench/cevs_mgmt_src.sv
// Model of system logic raising management requests.
// Assumes the bench pulses i_req for each request cycle.
`timescale 1ns/100ps
module cevs_mgmt_src (
    input wire logic i_ref_clk,
    input wire logic i_req,
    output logic o_req_n
);
    // Idles high as if pulled up, so no stale level is left on the pin
    initial o_req_n = 1'b1;
    always @(posedge i_ref_clk) o_req_n <= ~i_req;
endmodule

// File: testbench/cevs_top_monitor.sv
// Checker for the exception selection block.
// Assumes i_ce is held high throughout.
`timescale 1ns/100ps
module cevs_top_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire cevs_pkg::cevs_core_evt_t i_evt,
    input wire cevs_pkg::cevs_align_t i_align,
    input wire logic i_mgmt_req_n,
    input wire cevs_pkg::cevs_exc_t o_exc,
    input wire logic [2:0] o_align_rank
);
    import cevs_pkg::*;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_fp_unused: assert property (o_exc.offset != 20'h00e00)
        else $error("fp assist offset used");
    a_load_miss: assert property (i_evt.load_valid && i_evt.data_tb_miss
        && !i_evt.complete_valid |=> o_exc.take && o_exc.offset == 20'h01100)
        else $error("load miss not taken");
    a_store_miss: assert property (i_evt.store_valid && !i_evt.load_valid
        && (i_evt.data_tb_miss || i_evt.changed_bit_needed) && !i_evt.complete_valid
        |=> o_exc.take && o_exc.offset == 20'h01200) else $error("store miss not taken");
    a_vec_legal: assert property (o_exc.take |-> o_exc.offset inside
        {20'h01000, 20'h01100, 20'h01200, 20'h01300, 20'h01400}) else $error("bad offset");
    a_addr_form: assert property (o_exc.take |-> o_exc.addr[19:0] == o_exc.offset
        && o_exc.addr[31:20] inside {12'h000, 12'hfff}) else $error("bad entry address");
    a_mgmt_cause: assert property (o_exc.take && o_exc.offset == 20'h01400
        |-> !$past(i_mgmt_req_n, 3)) else $error("management take without request");
    a_bkpt_cause: assert property (o_exc.take && o_exc.offset == 20'h01300
        |-> $past(i_evt.complete_valid)) else $error("breakpoint without completion");
    a_rank_fp: assert property (i_align.valid && i_align.fp_operand
        |=> o_align_rank == 3'h1) else $error("fp alignment not ranked first");
    a_fetch_cause: assert property (o_exc.take && o_exc.offset == 20'h01000
        |-> $past(i_evt.fetch_valid && i_evt.fetch_tb_miss)) else $error("fetch take without miss");
endmodule
bind cevs_top cevs_top_monitor u_mon(.*);

// File: testbench/cevs_top_tb.sv
// Self-checking bench for the exception selection block.
// Assumes cevs_top, its bound checker and the request source model.
`timescale 1ns/100ps
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module cevs_top_tb;
    import cevs_pkg::*;
    logic i_ref_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, mgmt_req = 0, mgmt_n;
    logic [3:0] i_addr = 0;
    logic [31:0] i_wdata = 0, o_rdata;
    logic [2:0] rank;
    cevs_core_evt_t ev = '0;
    cevs_align_t al = '0;
    cevs_exc_t exc;
    int failures = 0, num_checks = 0, cyc = 0;
    always #20 i_ref_clk = ~i_ref_clk;
    cevs_mgmt_src u_src(.i_ref_clk(i_ref_clk), .i_req(mgmt_req), .o_req_n(mgmt_n));
    cevs_top u_dut(.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(ev),
        .i_align(al), .i_mgmt_req_n(mgmt_n), .o_exc(exc), .o_align_rank(rank));
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1;
        @(posedge i_ref_clk);
        i_wr <= 0;
    endtask
    task automatic rd_ck(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1;
        @(posedge i_ref_clk);
        i_rd <= 0;
        #1 `CK(o_rdata, e)
    endtask
    task automatic fire(input cevs_core_evt_t e, input logic [19:0] off, input logic [31:0] p);
        @(posedge i_ref_clk);
        ev <= e;
        @(posedge i_ref_clk);
        ev <= '0;
        #1 `CK(exc.take, off != 0)
        if (off != 0) `CK(exc.addr, p | off)
        `CK(exc.offset, off)
    endtask
    task automatic pulse(output logic seen);
        seen = 0;
        @(posedge i_ref_clk);
        mgmt_req <= 1;
        repeat (8) begin
            @(posedge i_ref_clk);
            mgmt_req <= 0;
            #1 seen |= exc.take === 1'b1 && exc.offset === 20'h01400;
        end
    endtask
    task automatic t_events;
        for (int a = 0; a < 6; a++) rd_ck(4'(a), 32'h0);
        fire({7'h60, 32'h0}, 20'h01000, 32'h0);
        fire({7'h14, 32'h0}, 20'h01100, 32'h0);
        fire({7'h0c, 32'h0}, 20'h01200, 32'h0);
        fire({7'h0a, 32'h0}, 20'h01200, 32'h0);
        fire({7'h08, 32'h0}, 20'h0, 32'h0);
        wr(4'h1, 32'h4);
        fire({7'h14, 32'h0}, 20'h01100, 32'hfff00000);
        wr(4'h0, 32'h00002468);
        fire({7'h01, 32'h00002468}, 20'h0, 32'h0);
        wr(4'h0, 32'h0000246b);
        rd_ck(4'h0, 32'h0000246a);
        fire({7'h01, 32'h0000246b}, 20'h01300, 32'hfff00000);
        fire({7'h01, 32'h0000346a}, 20'h0, 32'h0);
        fire({7'h15, 32'h00002468}, 20'h01300, 32'hfff00000);
        $display("events test done");
    endtask
    // Seen flags of the causes fired above, then a clear in the same cycle as a new cause
    task automatic t_status;
        rd_ck(4'h2, 32'h0000004e);
        rd_ck(4'h3, 32'hfff00000);
        @(posedge i_ref_clk);
        ev <= {7'h14, 32'h0};
        i_addr <= 4'h2;
        i_wdata <= 32'h000000ff;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        ev <= '0;
        i_wr <= 1'b0;
        rd_ck(4'h2, 32'h00000008);
        wr(4'h2, 32'h00000008);
        rd_ck(4'h2, 32'h0);
        $display("status test done");
    endtask
    task automatic t_align_mgmt;
        logic seen;
        wr(4'h1, 32'h2);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) wr(4'h1, 32'h0);
            @(posedge i_ref_clk);
            al <= {1'b1, 4'hf >> (i == 4 ? 3 : i)};
            @(posedge i_ref_clk);
            al <= '0;
            #1 `CK(rank, 3'(i == 4 ? 0 : i + 1))
        end
        pulse(seen);
        `CK(seen, 1'b0)
        wr(4'h1, 32'h1);
        pulse(seen);
        `CK(seen, 1'b1)
        $display("align and request test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Run takes well under a thousand cycles; the ceiling only catches a hang
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst <= 0;
        t_events;
        t_status;
        t_align_mgmt;
        tally_and_finish;
    end
endmodule
